// >>> dio_map_pkg.sv
// Purpose: Shared constants and carriers for the digital input object map
// Assumes: Object index plus sub-index form the register address
// Notes: Word objects use sub-index 1 only

package dio_map_pkg;

  // ----------------------------------------
  // Object indices
  // ----------------------------------------
  localparam logic [15:0] OBJ_DIAG_SEL = 16'h2000;
  localparam logic [15:0] OBJ_DIR_SEL = 16'h2001;
  localparam logic [15:0] OBJ_IN_BYTES = 16'h6000;
  localparam logic [15:0] OBJ_IN_WORD = 16'h6100;
  localparam logic [15:0] OBJ_POLARITY = 16'h6102;
  localparam logic [15:0] OBJ_MASKING = 16'h6103;

  // ----------------------------------------
  // Sub-indices and field layout
  // ----------------------------------------
  localparam logic [7:0] SUB_LOW = 8'h01;
  localparam logic [7:0] SUB_HIGH = 8'h02;
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 8;
  localparam int CH_PER_GROUP = 8;

  // ----------------------------------------
  // Reset values and unmapped read value
  // ----------------------------------------
  localparam logic [7:0] DIAG_SEL_RST = 8'h00;
  localparam logic [7:0] DIR_SEL_RST = 8'h00;
  localparam logic [15:0] POLARITY_RST = 16'h0000;
  localparam logic [15:0] MASKING_RST = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } obj_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } obj_rsp_t;

  typedef enum logic [1:0] {
    RSP_IDLE = 2'b00,
    RSP_DONE = 2'b01
  } rsp_state_t;

endpackage

// >>> input_conditioner.sv
// Purpose: Synchronise, invert and freeze one group of input pins
// Assumes: Pins are asynchronous to clock
// Notes: Frozen bits keep the last conditioned value unless valid is low, which forces them to zero

`timescale 1ns/1ps

module input_conditioner #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Pins and controls
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0] invert,
  input wire logic [WIDTH-1:0] freeze,
  input wire logic [WIDTH-1:0] valid,
  // Result
  output logic [WIDTH-1:0] state
);

  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] held;
  } cond_t;

  cond_t st_r;
  cond_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pin;
    st_nxt.sync2 = st_r.sync1;
    for (int i = 0; i < WIDTH; i++) begin
      // Output channels report zero so a stale input level never leaks out
      if (!valid[i]) begin
        st_nxt.held[i] = 1'b0;
      end else if (!freeze[i]) begin
        st_nxt.held[i] = st_r.sync2[i] ^ invert[i];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign state = st_r.held;

endmodule

// >>> digital_input_object_map.sv
// Purpose: Input object dictionary entries of a 16 channel splitter box
// Assumes: Master drives one-cycle rd or wr strobes on the object port
// Notes: Answer comes one cycle after the strobe
//
// Operation
// - Each diagnostics selection bit picks plain or diagnostics input, channels 10-17.
// - Diagnostics selection is a single byte covering channels 10 to 17 only.
// - Byte input sub-index 1 reports channels 0-7 configured as inputs.
// - Byte input sub-index 2 reports channels 10-17, plain or diagnostics per selection.
// - Word input holds channels 0-7 in bits 0-7, 10-17 in bits 8-15.
// - Byte input sub-index 1 always equals low byte of word input.
// - Sixteen bit polarity word, per channel, applies to selected input function.
// - Sixteen bit masking word, per channel, covers plain and diagnostics inputs.
// - Channels 0-7 set as outputs carry no input meaning in input objects.
// - Word, polarity, masking are 16-bit; selection and byte input are bytes.
// - Direction selection holds one bit per channel 0-7, input or output.

`timescale 1ns/1ps

module digital_input_object_map (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Object access from the network master
  input wire dio_map_pkg::obj_req_t req,
  output dio_map_pkg::obj_rsp_t rsp,
  // Channel pins
  input wire logic [7:0] pin_low,
  input wire logic [7:0] pin_high_plain,
  input wire logic [7:0] pin_high_diag,
  // Direction towards the output side of the unit
  output logic [7:0] channel_is_output
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] diag_function_select;
    logic [7:0] direction_select;
    logic [15:0] input_polarity_word;
    logic [15:0] input_masking_word;
    dio_map_pkg::rsp_state_t phase;
    dio_map_pkg::obj_rsp_t rsp;
    logic [7:0] plain_s1;
    logic [7:0] plain_s2;
    logic [7:0] diag_s1;
    logic [7:0] diag_s2;
    logic [7:0] high_held;
  } map_t;

  map_t st_r;
  map_t st_nxt;

  logic [7:0] low_state;
  logic [7:0] high_state;
  logic [7:0] high_sync_sel;
  logic [15:0] input_state_word;
  logic [7:0] low_valid;

  function automatic logic hit(input dio_map_pkg::obj_req_t r, input logic [15:0] idx,
                               input logic [7:0] sub);
    hit = (r.index == idx) && (r.sub == sub);
  endfunction

  // ----------------------------------------
  // Channel conditioning
  // ----------------------------------------
  assign low_valid = ~st_r.direction_select;

  input_conditioner #(.WIDTH(dio_map_pkg::CH_PER_GROUP)) u_low (
    .clock(clock),
    .nrst(nrst),
    .pin(pin_low),
    .invert(st_r.input_polarity_word[7:0]),
    .freeze(st_r.input_masking_word[7:0]),
    .valid(low_valid),
    .state(low_state)
  );

  // Both high pin sets are synchronised before the selection mux, so a
  // change of selection never exposes an unsynchronised level.
  always_comb begin
    for (int i = 0; i < dio_map_pkg::CH_PER_GROUP; i++) begin
      high_sync_sel[i] = st_r.diag_function_select[i] ?
                         st_r.diag_s2[i] : st_r.plain_s2[i];
    end
  end

  assign high_state = st_r.high_held;
  // Output channels are cleared here too, so a read right after a direction
  // change already shows zero instead of the last input level
  assign input_state_word = {high_state, low_state & low_valid};

  // ----------------------------------------
  // Object access
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Two-stage synchronisers on both high pin sets
    st_nxt.plain_s1 = pin_high_plain;
    st_nxt.plain_s2 = st_r.plain_s1;
    st_nxt.diag_s1 = pin_high_diag;
    st_nxt.diag_s2 = st_r.diag_s1;
    for (int i = 0; i < dio_map_pkg::CH_PER_GROUP; i++) begin
      if (!st_r.input_masking_word[dio_map_pkg::HIGH_LSB+i]) begin
        st_nxt.high_held[i] = high_sync_sel[i] ^
                              st_r.input_polarity_word[dio_map_pkg::HIGH_LSB+i];
      end
    end
    st_nxt.rsp = '0;
    st_nxt.phase = dio_map_pkg::RSP_IDLE;
    if (req.wr) begin
      st_nxt.phase = dio_map_pkg::RSP_DONE;
      st_nxt.rsp.ack = 1'b1;
      if (hit(req, dio_map_pkg::OBJ_DIAG_SEL, dio_map_pkg::SUB_LOW)) begin
        st_nxt.diag_function_select = req.wdata[7:0];
      end else if (hit(req, dio_map_pkg::OBJ_DIR_SEL, dio_map_pkg::SUB_LOW)) begin
        st_nxt.direction_select = req.wdata[7:0];
      end else if (hit(req, dio_map_pkg::OBJ_POLARITY, dio_map_pkg::SUB_LOW)) begin
        st_nxt.input_polarity_word = req.wdata;
      end else if (hit(req, dio_map_pkg::OBJ_MASKING, dio_map_pkg::SUB_LOW)) begin
        st_nxt.input_masking_word = req.wdata;
      end else begin
        // Read-only and unknown objects refuse writes
        st_nxt.rsp.err = 1'b1;
      end
    end else if (req.rd) begin
      st_nxt.phase = dio_map_pkg::RSP_DONE;
      st_nxt.rsp.ack = 1'b1;
      if (hit(req, dio_map_pkg::OBJ_DIAG_SEL, dio_map_pkg::SUB_LOW)) begin
        st_nxt.rsp.rdata = {8'h00, st_r.diag_function_select};
      end else if (hit(req, dio_map_pkg::OBJ_DIR_SEL, dio_map_pkg::SUB_LOW)) begin
        st_nxt.rsp.rdata = {8'h00, st_r.direction_select};
      end else if (hit(req, dio_map_pkg::OBJ_DIR_SEL, dio_map_pkg::SUB_HIGH)) begin
        st_nxt.rsp.rdata = dio_map_pkg::READ_UNMAPPED;
      end else if (hit(req, dio_map_pkg::OBJ_IN_BYTES, dio_map_pkg::SUB_LOW)) begin
        st_nxt.rsp.rdata = {8'h00, input_state_word[7:0]};
      end else if (hit(req, dio_map_pkg::OBJ_IN_BYTES, dio_map_pkg::SUB_HIGH)) begin
        st_nxt.rsp.rdata = {8'h00, input_state_word[15:8]};
      end else if (hit(req, dio_map_pkg::OBJ_IN_WORD, dio_map_pkg::SUB_LOW)) begin
        st_nxt.rsp.rdata = input_state_word;
      end else if (hit(req, dio_map_pkg::OBJ_POLARITY, dio_map_pkg::SUB_LOW)) begin
        // Output channel bits read as zero
        st_nxt.rsp.rdata = st_r.input_polarity_word & {8'hFF, low_valid};
      end else if (hit(req, dio_map_pkg::OBJ_MASKING, dio_map_pkg::SUB_LOW)) begin
        st_nxt.rsp.rdata = st_r.input_masking_word & {8'hFF, low_valid};
      end else begin
        st_nxt.rsp.err = 1'b1;
        st_nxt.rsp.rdata = dio_map_pkg::READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r.diag_function_select <= dio_map_pkg::DIAG_SEL_RST;
      st_r.direction_select <= dio_map_pkg::DIR_SEL_RST;
      st_r.input_polarity_word <= dio_map_pkg::POLARITY_RST;
      st_r.input_masking_word <= dio_map_pkg::MASKING_RST;
      st_r.phase <= dio_map_pkg::RSP_IDLE;
      st_r.rsp <= '0;
      st_r.plain_s1 <= 8'h00;
      st_r.plain_s2 <= 8'h00;
      st_r.diag_s1 <= 8'h00;
      st_r.diag_s2 <= 8'h00;
      st_r.high_held <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp = st_r.rsp;
  assign channel_is_output = st_r.direction_select;

endmodule

// >>> dio_map_properties.sv
// Purpose: Timing and mapping checks at the object port
// Assumes: One-cycle strobes, answer one edge later
// Notes: Sees only the top module ports
`timescale 1ns/1ps
module dio_map_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Object port and direction
  input wire dio_map_pkg::obj_req_t req,
  input wire dio_map_pkg::obj_rsp_t rsp,
  input wire logic [7:0] channel_is_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_req;
    req.rd || req.wr;
  endsequence
  sequence s_rd(logic [15:0] i);
    req.rd && !req.wr && req.index == i;
  endsequence
  property p_ack; s_req |=> rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing after strobe");
  property p_no_ack; !(req.rd || req.wr) |=> !rsp.ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack without strobe");
  property p_idle; !rsp.ack |-> rsp.rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("data outside answer");
  property p_dir;
    req.wr && req.index == 16'h2001 && req.sub == 8'h01
      |=> {8'h00, channel_is_output} == ($past(req.wdata) & 16'h00FF);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not taken");
  property p_ro;
    req.wr && (req.index == 16'h6100 || req.index == 16'h6000) |=> rsp.ack && rsp.err;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  property p_out;
    s_rd(16'h6100) |=> (rsp.rdata[7:0] & $past(channel_is_output)) == 8'h00;
  endproperty
  a_out: assert property (p_out) else $error("output channel shows input");
  property p_sel; s_rd(16'h2000) |=> rsp.rdata[15:8] == 8'h00; endproperty
  a_sel: assert property (p_sel) else $error("selection wider than byte");
  property p_bad;
    s_rd(16'h6000) ##0 req.sub > 8'h02 |=> rsp.err && rsp.rdata == 16'h0000;
  endproperty
  a_bad: assert property (p_bad) else $error("bad sub-index accepted");
endmodule
bind digital_input_object_map dio_map_properties chk (.clock(clock), .nrst(nrst),
  .req(req), .rsp(rsp), .channel_is_output(channel_is_output));

// >>> net_master.sv
// Purpose: Network master issuing object reads and writes
// Assumes: Strobe is a one-cycle pulse, answer exactly one edge later
// Notes: Released fields show inverted values so stale data is not trusted
`timescale 1ns/1ps
module net_master (
  // Clock
  input wire logic clock,
  // Object port
  output dio_map_pkg::obj_req_t req,
  input wire dio_map_pkg::obj_rsp_t rsp
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [15:0] d, output logic [15:0] q, output logic e, output logic ok);
    @(negedge clock);
    req = '{rd: !w, wr: w, index: i, sub: s, wdata: d};
    // The strobe is taken at the next rising edge and the answer stands for
    // the cycle after it, so it is read at this falling edge, then released
    @(negedge clock);
    ok = rsp.ack;
    q = rsp.rdata;
    e = rsp.err;
    req = '{rd: 1'b0, wr: 1'b0, index: ~i, sub: ~s, wdata: ~d};
  endtask
endmodule

// >>> digital_input_object_map_test.sv
// Purpose: Self-checking bench for the input object map
// Assumes: Pins settle within four cycles
// Notes: Expected words are built by hand from pin patterns
`timescale 1ns/1ps
module digital_input_object_map_test;
  logic clock;
  logic nrst;
  logic [7:0] pin_low, pin_high_plain, pin_high_diag, dir;
  dio_map_pkg::obj_req_t req;
  dio_map_pkg::obj_rsp_t rsp;
  int n_fail, cmp_count;
  digital_input_object_map DUT (.clock(clock), .nrst(nrst), .req(req), .rsp(rsp),
    .pin_low(pin_low), .pin_high_plain(pin_high_plain), .pin_high_diag(pin_high_diag),
    .channel_is_output(dir));
  net_master master (.clock(clock), .req(req), .rsp(rsp));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic op(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [15:0] d, input logic [15:0] q, input logic e);
    logic [15:0] rq;
    logic re, ok;
    master.xfer(w, i, s, d, rq, re, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
    chk("err", {15'h0000, e}, {15'h0000, re});
    if (!w) chk("rdata", q, rq);
  endtask
  task automatic pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(negedge clock);
    pin_low = a;
    pin_high_plain = b;
    pin_high_diag = c;
    repeat (4) @(negedge clock);
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
  initial begin
    n_fail = 0;
    cmp_count = 0;
    nrst = 1'b0;
    {pin_low, pin_high_plain, pin_high_diag} = '0;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    // Reset values
    op(0, 16'h2000, 8'h01, 0, 16'h0000, 0);
    op(0, 16'h6102, 8'h01, 0, 16'h0000, 0);
    op(0, 16'h6103, 8'h01, 0, 16'h0000, 0);
    op(0, 16'h2001, 8'h01, 0, 16'h0000, 0);
    pins(8'hA5, 8'h3C, 8'hC3);
    op(0, 16'h6100, 8'h01, 0, 16'h3CA5, 0);
    op(0, 16'h6000, 8'h01, 0, 16'h00A5, 0);
    op(0, 16'h6000, 8'h02, 0, 16'h003C, 0);
    // Low nibble picks the diagnostics pins; upper byte of data is dropped
    op(1, 16'h2000, 8'h01, 16'hFF0F, 0, 0);
    op(0, 16'h2000, 8'h01, 0, 16'h000F, 0);
    op(0, 16'h6000, 8'h02, 0, 16'h0033, 0);
    op(1, 16'h6102, 8'h01, 16'h0F01, 0, 0);
    op(0, 16'h6100, 8'h01, 0, 16'h3CA4, 0);
    op(0, 16'h6102, 8'h01, 0, 16'h0F01, 0);
    op(1, 16'h6103, 8'h01, 16'hFFFF, 0, 0);
    pins(8'h00, 8'h00, 8'h00);
    op(0, 16'h6100, 8'h01, 0, 16'h3CA4, 0);
    op(1, 16'h2001, 8'h01, 16'h00F0, 0, 0);
    chk("direction", 16'h00F0, {8'h00, dir});
    op(0, 16'h6100, 8'h01, 0, 16'h3C04, 0);
    op(0, 16'h6000, 8'h01, 0, 16'h0004, 0);
    op(0, 16'h6103, 8'h01, 0, 16'hFF0F, 0);
    op(0, 16'h2001, 8'h02, 0, 16'h0000, 0);
    // Refusals
    op(1, 16'h6100, 8'h01, 16'h1234, 0, 1);
    op(1, 16'h6000, 8'h01, 16'h1234, 0, 1);
    op(0, 16'h6000, 8'h03, 0, 16'h0000, 1);
    op(0, 16'h1234, 8'h01, 0, 16'h0000, 1);
    op(1, 16'h2001, 8'h02, 16'h00FF, 0, 1);
    // Second reset in mid-run returns the objects to their reset values
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    op(0, 16'h6102, 8'h01, 0, 16'h0000, 0);
    op(0, 16'h2001, 8'h01, 0, 16'h0000, 0);
    chk("direction", 16'h0000, {8'h00, dir});
    op(0, 16'h6100, 8'h01, 0, 16'h0000, 0);
    stop_test;
  end
endmodule
